//--- rtl/serializer_pkg.sv
// Constants shared by the byte serializer.
// Assumes one clock, clk, at 100 MHz, and a synchronous active-high reset.
// What this block does
// - Each byte leaves the serial output bit 0 first, bit 7 last.
// - Rate select picks a serial bit rate of one or two bits per clock.
// - Data flip-flops update on rising clock edges; arming and output selection update on falling edges.
// - Clock gate high stops conversion synchronously; low lets it run.
// - Rising sync input resets all internal flip-flops at once, without the clock.
// - After sync falls, the next falling edge arms; the next rising edge converts.
// - Sync held low acts as an enable, letting conversion continue.
// - Open data, rate, gate and true sync inputs read low.
// - The open complementary sync input reads high, so an open pair is released.
package serializer_pkg;
  localparam int WORD_BITS = 8;
  localparam int CNT_W = 3;
  localparam logic [2:0] CNT_RST = 3'h0;
  localparam logic [2:0] STEP_SINGLE = 3'h1;
  localparam logic [2:0] STEP_DOUBLE = 3'h2;
  localparam logic [7:0] WORD_RST = 8'h00;
  localparam logic BIT_RST = 1'b0;
  localparam int WORDCLK_BIT = 2;
endpackage : serializer_pkg

//--- rtl/byte_serializer_8to1.sv
// Eight-to-one parallel to serial converter with word clock output.
// Assumes parallel data, rate select and clock gate are launched from logic on clk;
// the sync pair may change at any time and acts as an asynchronous reset.
`timescale 1ns/10ps
module byte_serializer_8to1
  import serializer_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] parallel_data_in,
  input wire logic rate_select,
  input wire logic clock_gate,
  input wire logic conversion_sync,
  input wire logic conversion_sync_n,
  output logic serial_out,
  output logic word_clk
);

  // ----------------------------------------
  // Sync decode
  // ----------------------------------------
  // Open pins read true low, complement high: both decode as released
  wire sync_act = conversion_sync & ~conversion_sync_n;

  logic armed_ff;
  logic [2:0] cnt_ff;
  logic [7:0] word_ff;
  logic bit_a_ff;
  logic bit_b_ff;
  logic pos_ff;
  logic neg_ff;
  logic word_clk_ff;

  // ----------------------------------------
  // Divider and bit selection
  // ----------------------------------------
  wire run = armed_ff & ~clock_gate;
  wire [2:0] step = rate_select ? STEP_SINGLE : STEP_DOUBLE;
  wire [2:0] nxt_cnt = run ? cnt_ff + step : cnt_ff;
  // First bit of a byte is taken straight from the pins, so no load cycle is lost
  wire [7:0] sel_word = (cnt_ff == CNT_RST) ? parallel_data_in : word_ff;
  wire [2:0] cnt_b = cnt_ff + STEP_SINGLE;
  wire nxt_bit_a = sel_word[cnt_ff];
  wire nxt_bit_b = sel_word[cnt_b];
  wire nxt_word_clk = nxt_cnt[WORDCLK_BIT];

  // ----------------------------------------
  // Arming on the falling edge after sync release
  // ----------------------------------------
  always_ff @(negedge clk or posedge sync_act) begin
    if (sync_act) begin
      armed_ff <= 1'b0;
    end else if (rst) begin
      armed_ff <= 1'b0;
    end else begin
      armed_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // Rising-edge storage
  // ----------------------------------------
  always_ff @(posedge clk or posedge sync_act) begin
    if (sync_act || rst) begin
      cnt_ff <= CNT_RST;
      word_ff <= WORD_RST;
      bit_a_ff <= BIT_RST;
      bit_b_ff <= BIT_RST;
      pos_ff <= BIT_RST;
      word_clk_ff <= BIT_RST;
    end else begin
      cnt_ff <= nxt_cnt;
      if (run && cnt_ff == CNT_RST) begin
        word_ff <= parallel_data_in;
      end
      if (run) begin
        bit_a_ff <= nxt_bit_a;
        bit_b_ff <= nxt_bit_b;
      end
      pos_ff <= bit_b_ff;
      word_clk_ff <= nxt_word_clk;
    end
  end

  // ----------------------------------------
  // Falling-edge output selection
  // ----------------------------------------
  always_ff @(negedge clk or posedge sync_act) begin
    if (sync_act || rst) begin
      neg_ff <= BIT_RST;
    end else begin
      neg_ff <= bit_a_ff;
    end
  end

  // Double rate needs a change on both edges; this clock-phase select is the one
  // gate on the output, traded for halving the internal flop rate.
  assign serial_out = (!rate_select && clk) ? pos_ff : neg_ff;
  assign word_clk = word_clk_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_single_step;
    @(posedge clk) disable iff (rst || sync_act)
      run && rate_select |=> cnt_ff == $past(cnt_ff) + 3'h1;
  endproperty
  a_single_step: assert property (p_single_step) else $error("single rate divider slip");

  property p_double_step;
    @(posedge clk) disable iff (rst || sync_act)
      run && !rate_select |=> cnt_ff == $past(cnt_ff) + 3'h2;
  endproperty
  a_double_step: assert property (p_double_step) else $error("double rate divider slip");

  property p_gate_hold;
    @(posedge clk) disable iff (rst || sync_act)
      clock_gate |=> $stable(cnt_ff) && $stable(bit_a_ff);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gated converter moved");

  property p_word_clk;
    @(posedge clk) disable iff (rst || sync_act)
      word_clk_ff == cnt_ff[2];
  endproperty
  a_word_clk: assert property (p_word_clk) else $error("word clock off divider");

  property p_bit_order;
    @(posedge clk) disable iff (rst || sync_act)
      run && cnt_ff == 3'h0 |=> bit_a_ff == $past(parallel_data_in[0]);
  endproperty
  a_bit_order: assert property (p_bit_order) else $error("byte did not start at bit 0");

  property p_fall_mux;
    @(posedge clk) disable iff (rst || sync_act)
      armed_ff && $past(armed_ff) |-> neg_ff == bit_a_ff;
  endproperty
  a_fall_mux: assert property (p_fall_mux) else $error("falling edge output wrong");

  property p_first_word;
    @(posedge clk) disable iff (rst || sync_act)
      $rose(armed_ff) && !clock_gate |=> cnt_ff == (rate_select ? 3'h1 : 3'h2);
  endproperty
  a_first_word: assert property (p_first_word) else $error("conversion did not start");

  property p_stay_armed;
    @(posedge clk) disable iff (rst || sync_act)
      armed_ff |=> armed_ff;
  endproperty
  a_stay_armed: assert property (p_stay_armed) else $error("released sync dropped enable");

  // ----------------------------------------
  // Reset, arming, hold, load, pair bit and word clock checks
  // ----------------------------------------
  // Sync is not in the disable here: this check must see the asynchronous clear itself
  property p_sync_clear;
    @(posedge clk)
      sync_act |-> cnt_ff == CNT_RST && !word_clk_ff && !armed_ff && !neg_ff;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("sync left state behind");

  property p_rst_clear;
    @(posedge clk) disable iff (sync_act)
      rst |=> cnt_ff == CNT_RST && !word_clk_ff && !bit_a_ff;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset left state behind");

  property p_arm_after_release;
    @(negedge clk) disable iff (sync_act)
      !rst |=> armed_ff;
  endproperty
  a_arm_after_release: assert property (p_arm_after_release) else $error("converter not armed");

  property p_rst_disarm;
    @(negedge clk) disable iff (sync_act)
      rst |=> !armed_ff;
  endproperty
  a_rst_disarm: assert property (p_rst_disarm) else $error("reset left converter armed");

  property p_idle_hold;
    @(posedge clk) disable iff (rst || sync_act)
      !run |=> $stable(cnt_ff) && $stable(word_ff);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("stopped converter moved");

  property p_gate_bits;
    @(posedge clk) disable iff (rst || sync_act)
      clock_gate |=> $stable(bit_b_ff) && $stable(word_clk_ff);
  endproperty
  a_gate_bits: assert property (p_gate_bits) else $error("gated pair bit moved");

  property p_word_load;
    @(posedge clk) disable iff (rst || sync_act)
      run && cnt_ff == CNT_RST |=> word_ff == $past(parallel_data_in);
  endproperty
  a_word_load: assert property (p_word_load) else $error("byte not stored at wrap");

  property p_pair_second;
    @(posedge clk) disable iff (rst || sync_act)
      run && !rate_select && cnt_ff == CNT_RST |=> bit_b_ff == $past(parallel_data_in[1]);
  endproperty
  a_pair_second: assert property (p_pair_second) else $error("pair did not carry bit 1");

  property p_pos_follow;
    @(posedge clk) disable iff (rst || sync_act)
      armed_ff |=> pos_ff == $past(bit_b_ff);
  endproperty
  a_pos_follow: assert property (p_pos_follow) else $error("high phase bit late");

  property p_word_rise_single;
    @(posedge clk) disable iff (rst || sync_act)
      run && rate_select && cnt_ff == 3'h3 |=> word_clk_ff;
  endproperty
  a_word_rise_single: assert property (p_word_rise_single) else $error("word clock rise missed");

  property p_word_fall_single;
    @(posedge clk) disable iff (rst || sync_act)
      run && rate_select && cnt_ff == 3'h7 |=> !word_clk_ff;
  endproperty
  a_word_fall_single: assert property (p_word_fall_single) else $error("word clock fall missed");

  property p_word_fall_double;
    @(posedge clk) disable iff (rst || sync_act)
      run && !rate_select && cnt_ff == 3'h6 |=> !word_clk_ff;
  endproperty
  a_word_fall_double: assert property (p_word_fall_double) else $error("double rate word clock slip");

endmodule : byte_serializer_8to1

//--- tb/byte_source.sv
// Behavioural parallel byte source for the serializer bench.
// Assumes word_clk falls once per byte, one clock before the next byte is taken.
`timescale 1ns/10ps
module byte_source (
  input wire logic rst,
  input wire logic word_clk,
  input wire logic [7:0] seed,
  output logic [7:0] data
);
  // Moving on the falling word clock leaves a whole clock before the next capture
  always @(negedge word_clk or posedge rst) begin
    if (rst)
      data <= seed;
    else
      data <= data + 8'h35;
  end
endmodule : byte_source

//--- tb/byte_serializer_8to1_tb.sv
// Self-checking bench for the byte serializer.
// Assumes byte_source feeds the parallel data; open sync pins are driven to their pull levels.
`timescale 1ns/10ps
module byte_serializer_8to1_tb;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic [7:0] parallel_data_in;
  logic [7:0] seed = 8'h00;
  logic rate_select = 1'b1;
  logic clock_gate = 1'b0;
  logic conversion_sync = 1'b0;
  logic conversion_sync_n = 1'b1;
  logic serial_out;
  logic word_clk;
  int failures = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  byte_serializer_8to1 uut (.clk(clk), .rst(rst), .parallel_data_in(parallel_data_in),
    .rate_select(rate_select), .clock_gate(clock_gate), .conversion_sync(conversion_sync),
    .conversion_sync_n(conversion_sync_n), .serial_out(serial_out), .word_clk(word_clk));
  byte_source src (.rst(rst), .word_clk(word_clk), .seed(seed), .data(parallel_data_in));
  task automatic check(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: serial output or word clock wrong", $time);
    end
  endtask
  task automatic start(input logic r, input logic [7:0] s);
    seed <= s;
    @(posedge clk);
    rst <= 1'b1;
    rate_select <= r;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
  endtask
  // Samples 2 ns after each edge that launches a bit
  task automatic frame(input logic [7:0] d, input logic r);
    for (int k = 0; k < 8; k++) begin
      if (r || !k[0]) @(negedge clk);
      else @(posedge clk);
      #2;
      check(serial_out, d[k]);
      check(word_clk, r ? (k >= 3 && k < 7) : (k >= 1 && k < 5));
    end
  endtask
  task automatic rate_run(input logic r, input logic [7:0] s);
    start(r, s);
    @(posedge clk);
    frame(s, r);
    frame(s + 8'h35, r);
  endtask
  task automatic gate_hold;
    start(1'b1, 8'hc5);
    clock_gate <= 1'b1;
    repeat (4) begin
      @(negedge clk);
      #2;
      check(serial_out, 1'b0);
    end
    @(posedge clk);
    clock_gate <= 1'b0;
    @(posedge clk);
    frame(8'hc5, 1'b1);
  endtask
  task automatic sync_pulse;
    start(1'b1, 8'h2f);
    repeat (3) @(posedge clk);
    conversion_sync <= 1'b1;
    conversion_sync_n <= 1'b0;
    #1;
    check(serial_out, 1'b0);
    @(posedge clk);
    conversion_sync <= 1'b0;
    conversion_sync_n <= 1'b1;
    @(posedge clk);
    frame(8'h2f, 1'b1);
  endtask
  task automatic test_done;
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    rate_run(1'b1, 8'ha6);
    rate_run(1'b0, 8'h5c);
    gate_hold();
    sync_pulse();
    test_done();
  end
  // Hang guard
  initial begin
    #100000;
    failures++;
    test_done();
  end
endmodule : byte_serializer_8to1_tb
